// ---- rtl/frs_sequencer.sv ----
// Purpose: over-current fault response and restart sequencer gating the power stage
// Assumes: fault and voltage inputs are synchronous comparator levels
// Notes: loss of bias power is modelled by the synchronous reset
module frs_sequencer (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_code,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_code,
  input wire logic [frs_pkg::UNIT_W-1:0] i_delay_unit_cycles,
  input wire logic i_output_on_cmd,
  input wire logic i_clear_faults,
  input wire logic i_oc_detect,
  input wire logic i_vout_below_floor,
  input wire logic i_other_fault,
  output logic o_power_enable,
  output logic o_current_limit,
  output logic o_oc_fault_status,
  output logic o_host_alert,
  output logic [15:0] o_oc_threshold,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output logic [2:0] o_retry_count
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  frs_pkg::frs_state_e state_q, state_d;
  logic [15:0] threshold_q;
  logic [7:0] action_q;
  logic status_q, status_d;
  logic enable_q, limit_q, alert_q, rd_valid_q;
  logic [15:0] rd_data_q, rd_data_d;
  logic tmr_done, retry_allow;
  logic [2:0] retry_count;

  // configuration fields
  wire [1:0] mode = action_q[frs_pkg::RESP_MSB:frs_pkg::RESP_LSB];
  wire [2:0] retry_set = action_q[frs_pkg::RETRY_MSB:frs_pkg::RETRY_LSB];
  wire [2:0] delay_field = action_q[frs_pkg::DELAY_MSB:frs_pkg::DELAY_LSB];

  // register write decodes
  wire wr_threshold = i_wr_en && (i_wr_code == frs_pkg::CMD_OC_THRESHOLD);
  wire wr_action = i_wr_en && (i_wr_code == frs_pkg::CMD_OC_ACTION);
  wire wr_status = i_wr_en && (i_wr_code == frs_pkg::CMD_FAULT_STATUS);
  wire clr_status_bit = wr_status && i_wr_data[frs_pkg::STATUS_OC_BIT];

  // state decodes
  wire in_run = (state_q == frs_pkg::ST_RUN);
  wire in_limit = (state_q == frs_pkg::ST_LIMIT);
  wire in_wait = (state_q == frs_pkg::ST_WAIT);
  wire in_latched = (state_q == frs_pkg::ST_LATCHED);

  // fault events
  wire cmd_off = !i_output_on_cmd;
  wire oc_event = in_run && i_oc_detect;
  wire fault_clear = i_clear_faults || clr_status_bit;
  wire below_floor = (mode == frs_pkg::MODE_FLOOR_LIMIT) && i_vout_below_floor;
  wire shut_now = oc_event && ((mode == frs_pkg::MODE_SHUTDOWN) || below_floor);
  wire shut_limit = in_limit && (below_floor
    || ((mode == frs_pkg::MODE_DELAY_LIMIT) && tmr_done));
  wire shutdown = shut_now || shut_limit;
  wire stop_work = cmd_off || i_other_fault;

  // timer start: limiting window or retry spacing on the same count
  wire tmr_start_limit = oc_event && !shut_now && (mode == frs_pkg::MODE_DELAY_LIMIT);
  wire tmr_start_wait = !stop_work && shutdown && retry_allow;
  wire tmr_start = !stop_work && (tmr_start_limit || tmr_start_wait);
  wire tmr_stop = stop_work || (in_limit && !i_oc_detect);

  // attempt counter cleared on fault clear or off command
  wire retry_clear = cmd_off || fault_clear;
  wire retry_inc = tmr_start_wait;

  ////////////////////////////////////////////////////////////////////////////
  // delay timer and attempt counter
  frs_delay_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_start(tmr_start),
    .i_stop(tmr_stop),
    .i_field(delay_field),
    .i_unit_cycles(i_delay_unit_cycles),
    .o_done(tmr_done)
  );

  frs_retry_counter u_retry (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_clear(retry_clear),
    .i_inc(retry_inc),
    .i_setting(retry_set),
    .o_count(retry_count),
    .o_allow(retry_allow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: off command, then other fault, then the sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      frs_pkg::ST_OFF:
        if (i_output_on_cmd)
          state_d = frs_pkg::ST_RUN;
      frs_pkg::ST_RUN:
        if (shut_now)
          state_d = retry_allow ? frs_pkg::ST_WAIT : frs_pkg::ST_LATCHED;
        else if (i_oc_detect)
          state_d = frs_pkg::ST_LIMIT;
      frs_pkg::ST_LIMIT:
        if (shut_limit)
          state_d = retry_allow ? frs_pkg::ST_WAIT : frs_pkg::ST_LATCHED;
        else if (!i_oc_detect)
          state_d = frs_pkg::ST_RUN;
      frs_pkg::ST_WAIT:
        if (tmr_done)
          state_d = frs_pkg::ST_RUN;
      frs_pkg::ST_LATCHED:
        if (fault_clear)
          state_d = frs_pkg::ST_OFF;
      default:
        state_d = frs_pkg::ST_OFF;
    endcase
    if (i_other_fault)
      state_d = frs_pkg::ST_LATCHED;
    if (cmd_off)
      state_d = frs_pkg::ST_OFF;
  end

  // sticky status bit, a new event wins over a clear
  assign status_d = (oc_event || shutdown) ? 1'b1
    : (fault_clear ? 1'b0 : status_q);

  // read data mux, unknown codes read zero
  always_comb
  begin
    case (i_rd_code)
      frs_pkg::CMD_OC_THRESHOLD: rd_data_d = threshold_q;
      frs_pkg::CMD_OC_ACTION: rd_data_d = {8'h00, action_q};
      frs_pkg::CMD_FAULT_STATUS: rd_data_d = {11'h000, retry_count, state_q == frs_pkg::ST_LATCHED,
        status_q};
      default: rd_data_d = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      threshold_q <= frs_pkg::OC_THRESHOLD_RST;
      action_q <= frs_pkg::OC_ACTION_RST;
    end
    else if (i_ce)
    begin
      if (wr_threshold)
        threshold_q <= i_wr_data;
      if (wr_action)
        action_q <= i_wr_data[7:0];
    end
  end

  // sequencer state and registered outputs
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= frs_pkg::ST_OFF;
      status_q <= 1'b0;
      enable_q <= 1'b0;
      limit_q <= 1'b0;
      alert_q <= 1'b0;
    end
    else if (i_ce)
    begin
      state_q <= state_d;
      status_q <= status_d;
      enable_q <= (state_d == frs_pkg::ST_RUN) || (state_d == frs_pkg::ST_LIMIT);
      limit_q <= (state_d == frs_pkg::ST_LIMIT);
      alert_q <= status_d;
    end
  end

  // read port
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end
    else if (i_ce)
    begin
      rd_valid_q <= i_rd_en;
      if (i_rd_en)
        rd_data_q <= rd_data_d;
    end
  end

  assign o_power_enable = enable_q;
  assign o_current_limit = limit_q;
  assign o_oc_fault_status = status_q;
  assign o_host_alert = alert_q;
  assign o_oc_threshold = threshold_q;
  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_retry_count = retry_count;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  wire quiet = i_ce && !stop_work && !fault_clear;

  sequence s_shutdown_req;
    quiet && shutdown;
  endsequence

  sequence s_enter_wait;
    quiet && in_run && i_oc_detect && (mode == frs_pkg::MODE_SHUTDOWN) && retry_allow;
  endsequence

  sequence s_wait_done;
    quiet && in_wait && tmr_done;
  endsequence

  AST_MODE_SHUTDOWN_NOW: assert property (
    quiet && oc_event && (mode == frs_pkg::MODE_SHUTDOWN) |=> !o_power_enable && !o_current_limit)
    else $error("shutdown mode left the output on");

  AST_STATUS_ALERT: assert property (
    i_ce && oc_event |=> o_oc_fault_status && o_host_alert)
    else $error("fault status or alert not raised");

  AST_IGNORE_LIMITS: assert property (
    quiet && in_limit && (mode == frs_pkg::MODE_IGNORE) && i_oc_detect
    |=> o_current_limit && o_power_enable)
    else $error("ignore mode stopped limiting");

  AST_FLOOR_SHUTDOWN: assert property (
    quiet && in_limit && (mode == frs_pkg::MODE_FLOOR_LIMIT) && i_vout_below_floor
    |=> !o_power_enable)
    else $error("below floor did not shut down");

  AST_NO_RETRY: assert property (
    s_shutdown_req ##0 (retry_set == frs_pkg::RETRY_NONE) |=> in_latched && !o_power_enable)
    else $error("zero retry setting did restart");

  AST_RETRY_USED_UP: assert property (
    s_shutdown_req ##0 ((retry_set != frs_pkg::RETRY_FOREVER) && (retry_count == retry_set))
    |=> in_latched)
    else $error("restart beyond programmed count");

  AST_RETRY_FOREVER: assert property (
    s_shutdown_req ##0 (retry_set == frs_pkg::RETRY_FOREVER) |=> in_wait)
    else $error("unlimited retry stopped");

  AST_LATCH_HOLDS: assert property (
    quiet && in_latched |=> in_latched ##1 !o_power_enable)
    else $error("latched state left without clear");

  AST_COUNT_CLEARED: assert property (
    i_ce && retry_clear |=> (retry_count == 3'h0))
    else $error("attempt count not cleared");

  AST_ENTER_WAIT: assert property (
    s_enter_wait |=> in_wait && !o_power_enable)
    else $error("shutdown with retries left did not wait");

  AST_WAIT_TO_RESTART: assert property (
    s_wait_done |=> in_run && o_power_enable)
    else $error("retry did not restart at delay end");

  AST_OFF_CMD: assert property (
    i_ce && cmd_off |=> (state_q == frs_pkg::ST_OFF) && !o_power_enable)
    else $error("off command ignored");

endmodule : frs_sequencer

// ---- rtl/frs_pkg.sv ----
// Purpose: shared constants, state codes and helpers for the fault retry sequencer
// Assumes: one core clock, command codes arrive on a plain code/data port
// Notes: field positions follow the fault action byte layout
package frs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0] CMD_OC_THRESHOLD = 8'h46;
  localparam logic [7:0] CMD_OC_ACTION = 8'h47;
  localparam logic [7:0] CMD_FAULT_STATUS = 8'he0;

  // reset values
  localparam logic [15:0] OC_THRESHOLD_RST = 16'h0000;
  localparam logic [7:0] OC_ACTION_RST = 8'h00;

  // action byte fields
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam int STATUS_OC_BIT = 0;

  // response modes
  localparam logic [1:0] MODE_IGNORE = 2'h0;
  localparam logic [1:0] MODE_FLOOR_LIMIT = 2'h1;
  localparam logic [1:0] MODE_DELAY_LIMIT = 2'h2;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h3;

  // retry settings
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // timing widths
  localparam int UNIT_W = 16;
  localparam int DELAY_CNT_W = 23;
  localparam logic [UNIT_W-1:0] UNIT_MIN = 16'h0001;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_RUN = 5'h02,
    ST_LIMIT = 5'h04,
    ST_WAIT = 5'h08,
    ST_LATCHED = 5'h10
  } frs_state_e;

  // delay length in clock cycles: 2^field units of unit_cycles each
  function automatic logic [DELAY_CNT_W-1:0] frs_delay_cycles(input logic [2:0] field,
                                                              input logic [UNIT_W-1:0] unit);
    logic [UNIT_W-1:0] u;
    u = (unit == '0) ? UNIT_MIN : unit;
    frs_delay_cycles = DELAY_CNT_W'({7'h00, u} << field);
  endfunction : frs_delay_cycles

endpackage : frs_pkg

// ---- rtl/frs_delay_timer.sv ----
// Purpose: one-shot delay timer of 2^field delay units
// Assumes: start is a single-cycle request; stop may be held as a level while the output is commanded off
// Notes: done pulses for one enabled cycle at expiry
module frs_delay_timer (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [2:0] i_field,
  input wire logic [frs_pkg::UNIT_W-1:0] i_unit_cycles,
  output logic o_done
);

  logic [frs_pkg::DELAY_CNT_W-1:0] cnt_q;
  logic run_q;

  // expiry on the last counted cycle
  assign o_done = run_q && (cnt_q == frs_pkg::DELAY_CNT_W'(1));

  ////////////////////////////////////////////////////////////////////////////
  // down counter, restart wins over stop
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_start)
      begin
        cnt_q <= frs_pkg::frs_delay_cycles(i_field, i_unit_cycles);
        run_q <= 1'b1;
      end
      else if (i_stop || o_done)
        run_q <= 1'b0;
      else if (run_q)
        cnt_q <= cnt_q - frs_pkg::DELAY_CNT_W'(1);
    end
  end

endmodule : frs_delay_timer

// ---- rtl/frs_retry_counter.sv ----
// Purpose: counts restart attempts against the retry setting
// Assumes: clear has priority over increment
// Notes: the unlimited setting never exhausts and does not count
module frs_retry_counter (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_inc,
  input wire logic [2:0] i_setting,
  output logic [2:0] o_count,
  output logic o_allow
);

  logic [2:0] count_q;

  // another attempt is allowed while below the setting
  assign o_allow = (i_setting == frs_pkg::RETRY_FOREVER) || (count_q < i_setting);
  assign o_count = count_q;

  ////////////////////////////////////////////////////////////////////////////
  // attempt counter
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      count_q <= '0;
    else if (i_ce)
    begin
      if (i_clear)
        count_q <= '0;
      else if (i_inc && o_allow && (i_setting != frs_pkg::RETRY_FOREVER))
        count_q <= count_q + 3'h1;
    end
  end

endmodule : frs_retry_counter

// ---- dv/frs_host_model.sv ----
// Purpose: host side model issuing command writes, reads and on/off control
// Assumes: requests change just after a rising edge and last one cycle
// Notes: read answers are taken from the registered read pulse
module frs_host_model (
  input wire logic i_core_clk,
  input wire logic i_rd_valid,
  input wire logic [15:0] i_rd_data,
  output logic o_wr_en,
  output logic [7:0] o_wr_code,
  output logic [15:0] o_wr_data,
  output logic o_rd_en,
  output logic [7:0] o_rd_code,
  output logic o_on_cmd,
  output logic o_clear
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels at time zero
  initial
  begin
    o_wr_en = 1'b0;
    o_wr_code = 8'h00;
    o_wr_data = 16'h0000;
    o_rd_en = 1'b0;
    o_rd_code = 8'h00;
    o_on_cmd = 1'b0;
    o_clear = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle command write
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge i_core_clk);
    o_wr_en <= 1'b1;
    o_wr_code <= code;
    o_wr_data <= data;
    @(posedge i_core_clk);
    o_wr_en <= 1'b0;
  endtask : wr

  // one-cycle read, answer one cycle later
  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
    @(posedge i_core_clk);
    o_rd_en <= 1'b1;
    o_rd_code <= code;
    @(posedge i_core_clk);
    o_rd_en <= 1'b0;
    #1;
    ok = i_rd_valid;
    data = i_rd_data;
  endtask : rd

  // clear-faults pulse only
  task automatic clear_pulse();
    @(posedge i_core_clk);
    o_clear <= 1'b1;
    @(posedge i_core_clk);
    o_clear <= 1'b0;
  endtask : clear_pulse

  // off, clear, then on again
  task automatic power_cycle();
    @(posedge i_core_clk);
    o_on_cmd <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    clear_pulse();
    o_on_cmd <= 1'b1;
    repeat (4) @(posedge i_core_clk);
  endtask : power_cycle
endmodule : frs_host_model

// ---- dv/tb_fault_retry_response_sequencer.sv ----
// Purpose: self-checking bench for the over-current fault retry sequencer
// Assumes: host model drives the command port and on/off control
// Notes: delay unit kept small so every retry run stays short
module tb_fault_retry_response_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, oc, below, other, pe_q;
  logic wr_en, rd_en, on_cmd, clr, pe, lim, st, alert, rv, rok;
  logic [7:0] wr_code, rd_code;
  logic [15:0] unit, wr_data, thr, rd_data, rdat;
  logic [2:0] cnt;
  int err_total, checks_done, cyc, rises, k;

  frs_sequencer u_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_wr_en(wr_en), .i_wr_code(wr_code), .i_wr_data(wr_data),
    .i_rd_en(rd_en), .i_rd_code(rd_code), .i_delay_unit_cycles(unit),
    .i_output_on_cmd(on_cmd), .i_clear_faults(clr), .i_oc_detect(oc),
    .i_vout_below_floor(below), .i_other_fault(other), .o_power_enable(pe),
    .o_current_limit(lim), .o_oc_fault_status(st), .o_host_alert(alert),
    .o_oc_threshold(thr), .o_rd_data(rd_data), .o_rd_valid(rv), .o_retry_count(cnt)
  );

  frs_host_model u_host (
    .i_core_clk(clk), .i_rd_valid(rv), .i_rd_data(rd_data), .o_wr_en(wr_en),
    .o_wr_code(wr_code), .o_wr_data(wr_data), .o_rd_en(rd_en), .o_rd_code(rd_code),
    .o_on_cmd(on_cmd), .o_clear(clr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, restart counter and hang guard
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (pe === 1'b1 && pe_q !== 1'b1) rises++;
    pe_q = pe;
    if (cyc > 40000)
    begin
      err_total++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task automatic results();
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // wait for level lvl, then count cycles it lasts
  task automatic span(input bit sel, input logic lvl, output int n);
    #1;
    n = 0;
    while (((sel ? lim : pe) !== lvl) && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (((sel ? lim : pe) === lvl) && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : span

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    oc = 1'b0;
    below = 1'b0;
    other = 1'b0;
    unit = 16'h0002;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // register access
    u_host.rd(frs_pkg::CMD_OC_THRESHOLD, rdat, rok);
    check("thr_rst", 32'h0, rdat);
    u_host.wr(frs_pkg::CMD_OC_THRESHOLD, 16'hbeef);
    u_host.rd(frs_pkg::CMD_OC_THRESHOLD, rdat, rok);
    check("thr_rd", 32'hbeef, rdat);
    check("rd_valid", 32'h1, rok);
    check("thr_out", 32'hbeef, thr);
    u_host.wr(frs_pkg::CMD_OC_ACTION, 16'hffa5);
    u_host.rd(frs_pkg::CMD_OC_ACTION, rdat, rok);
    check("act_rd", 32'h00a5, rdat);
    u_host.rd(8'h33, rdat, rok);
    check("unknown_rd", 32'h0, rdat);
    // mode 11, every retry setting, fault held on
    for (int r = 0; r < 8; r++)
    begin
      u_host.wr(frs_pkg::CMD_OC_ACTION, {8'h00, 2'b11, 3'(r), 3'b000});
      u_host.power_cycle();
      check("on", 32'h1, pe);
      rises = 0;
      @(posedge clk);
      oc <= 1'b1;
      repeat (8 * r + 12) @(posedge clk);
      #1;
      check("status", 32'h1, st);
      check("alert", 32'h1, alert);
      if (r < 7)
      begin
        check("restarts", 32'(r), 32'(rises));
        check("latched", 32'h0, pe);
        check("count", 32'(r), cnt);
        u_host.rd(frs_pkg::CMD_FAULT_STATUS, rdat, rok);
        check("stat_rd", 32'((r << 2) | 3), rdat);
      end
      else
        check("unlimited", 32'h1, rises > 7);
      @(posedge clk);
      oc <= 1'b0;
      u_host.power_cycle();
      check("count_clr", 32'h0, cnt);
    end
    // restart spacing over every delay field, unit of three cycles
    unit <= 16'h0003;
    for (int f = 0; f < 8; f++)
    begin
      u_host.wr(frs_pkg::CMD_OC_ACTION, {8'h00, 2'b11, 3'b111, 3'(f)});
      u_host.power_cycle();
      @(posedge clk);
      oc <= 1'b1;
      span(1'b0, 1'b1, k);
      span(1'b0, 1'b0, k);
      check("spacing", 32'(3 << f), 32'(k));
      @(posedge clk);
      oc <= 1'b0;
    end
    // mode 10: limit for the delay, then retry setting 000
    unit <= 16'h0002;
    u_host.wr(frs_pkg::CMD_OC_ACTION, 16'h0081);
    u_host.power_cycle();
    @(posedge clk);
    oc <= 1'b1;
    span(1'b1, 1'b1, k);
    check("limit_len", 32'h4, 32'(k));
    check("off_after", 32'h0, pe);
    @(posedge clk);
    oc <= 1'b0;
    u_host.power_cycle();
    oc <= 1'b1;
    repeat (2) @(posedge clk);
    oc <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("limit_drop", 32'h0, lim);
    check("still_on", 32'h1, pe);
    // mode 00 limits forever, mode 01 until below floor
    for (int m = 0; m < 2; m++)
    begin
      u_host.wr(frs_pkg::CMD_OC_ACTION, {8'h00, 1'b0, 1'(m), 6'h00});
      u_host.power_cycle();
      oc <= 1'b1;
      repeat (60) @(posedge clk);
      #1;
      check("limit_hold", 32'h1, lim);
      check("on_hold", 32'h1, pe);
      @(posedge clk);
      below <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("floor", 32'(m == 0), pe);
      @(posedge clk);
      below <= 1'b0;
      oc <= 1'b0;
    end
    // status bit write clears the floor shutdown latch
    #1;
    check("status_set", 32'h1, st);
    u_host.wr(frs_pkg::CMD_FAULT_STATUS, 16'h0001);
    #1;
    check("bit_clear", 32'h0, st);
    repeat (3) @(posedge clk);
    #1;
    check("bit_recover", 32'h1, pe);
    // other fault latches off; clear-faults recovers
    u_host.power_cycle();
    other <= 1'b1;
    @(posedge clk);
    other <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("other_off", 32'h0, pe);
    u_host.clear_pulse();
    repeat (3) @(posedge clk);
    #1;
    check("recover", 32'h1, pe);
    results();
  end
endmodule : tb_fault_retry_response_sequencer
